// file: shared/pegpio_pkg.sv
// Package with register map, field positions and reset values of port E.
package pegpio_pkg;
    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [3:0] PEGPIO_PIN_VALUE_ADDR = 4'h0;
    localparam logic [3:0] PEGPIO_LATCH_ADDR = 4'h1;
    localparam logic [3:0] PEGPIO_DIRECTION_ADDR = 4'h2;
    localparam logic [3:0] PEGPIO_ANALOG_ADDR = 4'h3;
    localparam logic [3:0] PEGPIO_SLEW_ADDR = 4'h4;
    localparam logic [3:0] PEGPIO_INT_CTL_TWO_ADDR = 4'h5;
    localparam logic [3:0] PEGPIO_CFG_THREE_HI_ADDR = 4'h6;
    localparam logic [3:0] PEGPIO_CFG_FOUR_LO_ADDR = 4'h7;
    localparam logic [3:0] PEGPIO_PERIPH_ADDR = 4'h8;
    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int PEGPIO_PULLUP_EN_BIT = 7;
    localparam int PEGPIO_INPUT_PIN_BIT = 3;
    localparam int PEGPIO_SLEW_BIT = 4;
    localparam int PEGPIO_GPU_DIS_BIT = 7;
    localparam int PEGPIO_CLR_EN_BIT = 7;
    localparam int PEGPIO_MUX3_BIT = 2;
    localparam int PEGPIO_LV_PROG_BIT = 2;
    // ------------------------------------------------------------------
    // Reset values and masks.
    // ------------------------------------------------------------------
    localparam logic [2:0] PEGPIO_DIR_RST = 3'h7;
    localparam logic [2:0] PEGPIO_ANA_RST = 3'h7;
    localparam logic [2:0] PEGPIO_LAT_RST = 3'h0;
    localparam logic PEGPIO_PULLUP_RST = 1'b0;
    localparam logic [4:0] PEGPIO_SLEW_RST = 5'h1F;
    localparam logic PEGPIO_GPU_DIS_RST = 1'b1;
    localparam logic [7:0] PEGPIO_ZERO_BYTE = 8'h00;
endpackage

// file: verification/pegpio_board_model.sv
// Board model that resolves the levels seen on the four port E pins.
`timescale 1ns/10ps
module pegpio_board_model
(
    input wire logic core_clk_i,
    input wire logic [2:0] pin_out_i,
    input wire logic [2:0] pin_oe_i,
    input wire logic pullup_i,
    input wire logic [3:0] ext_lvl_i,
    input wire logic [3:0] ext_drv_i,
    output logic [3:0] pin_lvl_o
);
    logic [3:0] last_r;
    // ------------------------------------------------------------------
    // Pin resolution; an undriven line shows the inverse of its last level, except pin 3, which shows 1 when pulled up.
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (pin_oe_i[i])
                pin_lvl_o[i] = pin_out_i[i];
            else if (ext_drv_i[i])
                pin_lvl_o[i] = ext_lvl_i[i];
            else
                pin_lvl_o[i] = ~last_r[i];
        end
        if (ext_drv_i[3])
            pin_lvl_o[3] = ext_lvl_i[3];
        else if (pullup_i)
            pin_lvl_o[3] = 1'b1;
        else
            pin_lvl_o[3] = ~last_r[3];
    end
    always_ff @(posedge core_clk_i)
        last_r <= pin_lvl_o;
endmodule // pegpio_board_model

// file: verification/pegpio_port_e_tb_top.sv
// Self-checking testbench for the port E block.
`timescale 1ns/10ps
module pegpio_port_e_tb_top;
    import pegpio_pkg::*;
    logic clk, arst_n, wr_s, rd_s, clr_en, lv_prog, mux, pu, pbg, slew_lim;
    logic mrst;
    logic pa_en, pa, c3_en, c3, pb_en, pb, c5_en, c5;
    logic [3:0] addr, pin_in, ext_lvl, ext_drv;
    logic [7:0] wdata, rdata, v;
    logic [2:0] pin_out, pin_oe, ana;
    logic [4:0] slew;
    int error_cnt, compares;
    // ------------------------------------------------------------------
    // Instances.
    // ------------------------------------------------------------------
    pegpio_port_e pegpio_port_e_i (.core_clk_i(clk), .arst_n_i(arst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .master_clear_enable_i(clr_en),
        .low_voltage_programming_enable_i(lv_prog),
        .capcomp3_pin_mux_i(mux),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .analog_en_o(ana), .input_only_pin_pullup_o(pu),
        .port_b_pullup_gate_o(pbg), .port_e_slew_limited_o(slew_lim),
        .slew_rate_control_o(slew), .master_clear_reset_o(mrst),
        .pwm3_output_a_en_i(pa_en), .pwm3_output_a_i(pa),
        .capcomp_unit3_en_i(c3_en), .capcomp_unit3_i(c3),
        .pwm3_output_b_en_i(pb_en), .pwm3_output_b_i(pb),
        .capcomp_unit5_en_i(c5_en), .capcomp_unit5_i(c5));
    pegpio_board_model pegpio_board_model_i (.core_clk_i(clk),
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pullup_i(pu),
        .ext_lvl_i(ext_lvl), .ext_drv_i(ext_drv), .pin_lvl_o(pin_in));
    always #2 clk = ~clk;
    // ------------------------------------------------------------------
    // Bus tasks and checks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #40000;
        error_cnt++;
        conclude();
    end
    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial
    begin
        clk = 0; arst_n = 0; wr_s = 0; rd_s = 0; addr = '0; wdata = '0;
        clr_en = 0; lv_prog = 0; mux = 1; ext_lvl = 4'hF; ext_drv = 4'hF;
        {pa_en, pa, c3_en, c3, pb_en, pb, c5_en, c5} = 8'h00;
        error_cnt = 0; compares = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        cyc(1);
        chk({5'h0, pin_oe}, 8'h00);
        chk({5'h0, ana}, {5'h0, PEGPIO_ANA_RST});
        chk({7'h0, pu}, 8'h00);
        chk({7'h0, slew_lim}, 8'h01);
        v = {PEGPIO_PULLUP_RST, 4'h0, PEGPIO_DIR_RST};
        rdchk(PEGPIO_DIRECTION_ADDR, v);
        rdchk(PEGPIO_ANALOG_ADDR, 8'h07);
        rdchk(PEGPIO_SLEW_ADDR, {3'h0, PEGPIO_SLEW_RST});
        rdchk(PEGPIO_INT_CTL_TWO_ADDR, 8'h80);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h08);
        wr(PEGPIO_PIN_VALUE_ADDR, 8'hFD);
        rdchk(PEGPIO_LATCH_ADDR, 8'h05);
        ext_drv <= 4'h8;
        wr(PEGPIO_DIRECTION_ADDR, 8'h78);
        rdchk(PEGPIO_DIRECTION_ADDR, 8'h00);
        cyc(1);
        chk({5'h0, pin_oe}, 8'h07);
        chk({5'h0, pin_out}, 8'h05);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h08);
        wr(PEGPIO_ANALOG_ADDR, 8'hF8);
        rdchk(PEGPIO_ANALOG_ADDR, 8'h00);
        cyc(3);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h0D);
        ext_drv <= 4'h9;
        ext_lvl <= 4'h8;
        wr(PEGPIO_DIRECTION_ADDR, 8'h01);
        cyc(4);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h0C);
        rd(PEGPIO_LATCH_ADDR, v);
        chk(v, 8'h05);
        wr(PEGPIO_LATCH_ADDR, v | 8'h02);
        rdchk(PEGPIO_LATCH_ADDR, 8'h07);
        wr(4'hF, 8'hFF);
        rdchk(4'hF, 8'h00);
        @(posedge clk);
        lv_prog <= 1'b1;
        wr(PEGPIO_CFG_THREE_HI_ADDR, 8'h80);
        rdchk(PEGPIO_CFG_THREE_HI_ADDR, 8'h04);
        rdchk(PEGPIO_CFG_FOUR_LO_ADDR, 8'h04);
        chk({7'h0, pu}, 8'h01);
        @(posedge clk);
        lv_prog <= 1'b0;
        cyc(3);
        chk({7'h0, pu}, 8'h00);
        wr(PEGPIO_INT_CTL_TWO_ADDR, 8'h00);
        wr(PEGPIO_DIRECTION_ADDR, 8'h81);
        cyc(2);
        chk({6'h0, pu, pbg}, 8'h03);
        wr(PEGPIO_INT_CTL_TWO_ADDR, 8'h80);
        cyc(2);
        chk({6'h0, pu, pbg}, 8'h00);
        @(posedge clk);
        clr_en <= 1'b1;
        ext_lvl <= 4'h0;
        cyc(4);
        chk({6'h0, pu, mrst}, 8'h03);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h06);
        @(posedge clk);
        clr_en <= 1'b0;
        ext_lvl <= 4'h8;
        cyc(4);
        chk({7'h0, mrst}, 8'h00);
        rdchk(PEGPIO_PIN_VALUE_ADDR, 8'h0E);
        wr(PEGPIO_SLEW_ADDR, 8'hE0);
        rdchk(PEGPIO_SLEW_ADDR, 8'h00);
        chk({2'h0, slew_lim, slew}, 8'h00);
        wr(PEGPIO_LATCH_ADDR, 8'h00);
        wr(PEGPIO_ANALOG_ADDR, 8'h07);
        wr(PEGPIO_DIRECTION_ADDR, 8'h80);
        @(posedge clk);
        {pa_en, pa, c3_en, c3, pb_en, pb, c5_en, c5} <= 8'hEF;
        cyc(3);
        chk({5'h0, pin_out}, 8'h06);
        @(posedge clk);
        mux <= 1'b0;
        cyc(3);
        chk({5'h0, pin_out}, 8'h07);
        @(posedge clk);
        {pa_en, pa, c3_en, c3} <= 4'h6;
        cyc(3);
        chk({5'h0, pin_out}, 8'h06);
        @(posedge clk);
        c3 <= 1'b1;
        cyc(3);
        chk({5'h0, pin_out}, 8'h07);
        arst_n <= 1'b0;
        cyc(2);
        chk({5'h0, pin_oe}, 8'h00);
        arst_n <= 1'b1;
        rdchk(PEGPIO_DIRECTION_ADDR, 8'h07);
        rdchk(PEGPIO_ANALOG_ADDR, 8'h07);
        rdchk(PEGPIO_LATCH_ADDR, 8'h00);
        conclude();
    end
endmodule // pegpio_port_e_tb_top

// file: verilog/pegpio_port_e.sv
// Port E general purpose I/O block with analog select and slew control.
`timescale 1ns/10ps
module pegpio_port_e
    import pegpio_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
)
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic master_clear_enable_i,
    input wire logic low_voltage_programming_enable_i,
    input wire logic capcomp3_pin_mux_i,
    input wire logic [3:0] pin_in_i,
    output logic [2:0] pin_out_o,
    output logic [2:0] pin_oe_o,
    output logic [2:0] analog_en_o,
    output logic input_only_pin_pullup_o,
    output logic port_b_pullup_gate_o,
    output logic port_e_slew_limited_o,
    output logic [4:0] slew_rate_control_o,
    output logic master_clear_reset_o,
    input wire logic pwm3_output_a_en_i,
    input wire logic pwm3_output_a_i,
    input wire logic capcomp_unit3_en_i,
    input wire logic capcomp_unit3_i,
    input wire logic pwm3_output_b_en_i,
    input wire logic pwm3_output_b_i,
    input wire logic capcomp_unit5_en_i,
    input wire logic capcomp_unit5_i
);
    // ------------------------------------------------------------------
    // Pin synchroniser.
    // ------------------------------------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= pin_in_i;
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------------
    // Software registers.
    // ------------------------------------------------------------------
    logic [2:0] lat_r, lat_nxt;
    logic [2:0] dir_r, dir_nxt;
    logic [2:0] ana_r, ana_nxt;
    logic pu_en_r, pu_en_nxt;
    logic [4:0] slew_r, slew_nxt;
    logic gpu_dis_r, gpu_dis_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] pin_val;
    logic [2:0] dig_in;
    logic clr_mode;

    assign clr_mode = master_clear_enable_i;

    always_comb
    begin
        dig_in = sync2_r[2:0] & ~ana_r;
        pin_val = PEGPIO_ZERO_BYTE;
        if (LARGE_PKG)
            pin_val[2:0] = dig_in;
        if (!clr_mode)
            pin_val[PEGPIO_INPUT_PIN_BIT] = sync2_r[3];
    end

    always_comb
    begin
        lat_nxt = lat_r;
        dir_nxt = dir_r;
        ana_nxt = ana_r;
        pu_en_nxt = pu_en_r;
        slew_nxt = slew_r;
        gpu_dis_nxt = gpu_dis_r;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                PEGPIO_PIN_VALUE_ADDR,
                PEGPIO_LATCH_ADDR:
                    if (LARGE_PKG)
                        lat_nxt = reg_wdata_i[2:0];
                PEGPIO_DIRECTION_ADDR:
                begin
                    if (LARGE_PKG)
                        dir_nxt = reg_wdata_i[2:0];
                    pu_en_nxt = reg_wdata_i[PEGPIO_PULLUP_EN_BIT];
                end
                PEGPIO_ANALOG_ADDR:
                    if (LARGE_PKG)
                        ana_nxt = reg_wdata_i[2:0];
                PEGPIO_SLEW_ADDR:
                    slew_nxt = reg_wdata_i[4:0];
                PEGPIO_INT_CTL_TWO_ADDR:
                    gpu_dis_nxt = reg_wdata_i[PEGPIO_GPU_DIS_BIT];
                default:
                    lat_nxt = lat_r;
            endcase
        end
    end

    always_comb
    begin
        rdata_nxt = PEGPIO_ZERO_BYTE;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                PEGPIO_PIN_VALUE_ADDR:
                    rdata_nxt = pin_val;
                PEGPIO_LATCH_ADDR:
                    rdata_nxt = {5'h00, lat_r};
                PEGPIO_DIRECTION_ADDR:
                    rdata_nxt = {pu_en_r, 4'h0, dir_r};
                PEGPIO_ANALOG_ADDR:
                    rdata_nxt = {5'h00, ana_r};
                PEGPIO_SLEW_ADDR:
                    rdata_nxt = {3'h0, slew_r};
                PEGPIO_INT_CTL_TWO_ADDR:
                    rdata_nxt = {gpu_dis_r, 7'h00};
                PEGPIO_CFG_THREE_HI_ADDR:
                    rdata_nxt = {master_clear_enable_i, 4'h0,
                        capcomp3_pin_mux_i, 2'h0};
                PEGPIO_CFG_FOUR_LO_ADDR:
                    rdata_nxt = {5'h00, low_voltage_programming_enable_i,
                        2'h0};
                default:
                    rdata_nxt = PEGPIO_ZERO_BYTE;
            endcase
            if (!LARGE_PKG && reg_addr_i inside {PEGPIO_LATCH_ADDR,
                PEGPIO_DIRECTION_ADDR, PEGPIO_ANALOG_ADDR})
                rdata_nxt[2:0] = 3'h0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lat_r <= PEGPIO_LAT_RST;
            dir_r <= PEGPIO_DIR_RST;
            ana_r <= PEGPIO_ANA_RST;
            pu_en_r <= PEGPIO_PULLUP_RST;
            slew_r <= PEGPIO_SLEW_RST;
            gpu_dis_r <= PEGPIO_GPU_DIS_RST;
            rdata_r <= PEGPIO_ZERO_BYTE;
        end
        else
        begin
            lat_r <= lat_nxt;
            dir_r <= dir_nxt;
            ana_r <= ana_nxt;
            pu_en_r <= pu_en_nxt;
            slew_r <= slew_nxt;
            gpu_dis_r <= gpu_dis_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers with peripheral priority.
    // ------------------------------------------------------------------
    logic [2:0] out_nxt, oe_nxt, out_r, oe_r;
    logic pu_nxt, pu_r, clr_rst_nxt, clr_rst_r;
    logic pbg_nxt, pbg_r;
    logic pwm_a_on, cc3_on;

    always_comb
    begin
        pwm_a_on = pwm3_output_a_en_i && !capcomp3_pin_mux_i;
        cc3_on = capcomp_unit3_en_i && !capcomp3_pin_mux_i;
        out_nxt = lat_r;
        oe_nxt = ~dir_r;
        // Peripherals override the latch regardless of analog select.
        if (pwm_a_on)
            out_nxt[0] = pwm3_output_a_i;
        else if (cc3_on)
            out_nxt[0] = capcomp_unit3_i;
        if (pwm3_output_b_en_i)
            out_nxt[1] = pwm3_output_b_i;
        if (capcomp_unit5_en_i)
            out_nxt[2] = capcomp_unit5_i;
        if (!LARGE_PKG)
        begin
            out_nxt = 3'h0;
            oe_nxt = 3'h0;
        end
        if (master_clear_enable_i && !low_voltage_programming_enable_i)
            pu_nxt = 1'b1;
        else if (low_voltage_programming_enable_i)
            pu_nxt = 1'b1;
        else
            pu_nxt = pu_en_r && !gpu_dis_r;
        clr_rst_nxt = clr_mode && !sync2_r[3];
        pbg_nxt = !gpu_dis_r;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            out_r <= 3'h0;
            oe_r <= 3'h0;
            pu_r <= 1'b0;
            clr_rst_r <= 1'b0;
            pbg_r <= 1'b0;
        end
        else
        begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            clr_rst_r <= clr_rst_nxt;
            pbg_r <= pbg_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign pin_out_o = out_r;
    assign pin_oe_o = oe_r;
    assign analog_en_o = ana_r;
    assign input_only_pin_pullup_o = pu_r;
    assign port_b_pullup_gate_o = pbg_r;
    assign port_e_slew_limited_o = slew_r[PEGPIO_SLEW_BIT];
    assign slew_rate_control_o = slew_r;
    assign master_clear_reset_o = clr_rst_r;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    sequence pin_read_s;
        reg_rd_i && reg_addr_i == PEGPIO_PIN_VALUE_ADDR;
    endsequence
    sequence pin_write_s;
        reg_wr_i && reg_addr_i == PEGPIO_PIN_VALUE_ADDR;
    endsequence
    sequence latch_read_s;
        reg_rd_i && reg_addr_i == PEGPIO_LATCH_ADDR;
    endsequence

    analog_read_zero_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        pin_read_s
        |=> (reg_rdata_o[2:0] & ana_r) == 3'h0)
        else $error("analog pin read nonzero");
    dir_drive_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        ##1 LARGE_PKG |-> pin_oe_o == ~$past(dir_r))
        else $error("driver enable wrong");
    latch_rmw_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        latch_read_s |=> reg_rdata_o[2:0] == $past(lat_r) || !LARGE_PKG)
        else $error("latch readback wrong");
    lat_write_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        pin_write_s |=> lat_r == $past(reg_wdata_i[2:0]) || !LARGE_PKG)
        else $error("pin register write missed latch");
    clr_read_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        reg_rd_i && master_clear_enable_i
        |=> reg_rdata_o[PEGPIO_INPUT_PIN_BIT] == 1'b0
        || $past(reg_addr_i) != PEGPIO_PIN_VALUE_ADDR)
        else $error("input pin visible in clear mode");
    clr_off_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        !master_clear_enable_i |=> !master_clear_reset_o)
        else $error("clear reset while port pin");
    clr_reset_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        master_clear_enable_i && !sync2_r[3] |=> master_clear_reset_o)
        else $error("master clear missed");
    pullup_gate_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        gpu_dis_r && !master_clear_enable_i
        && !low_voltage_programming_enable_i
        |=> !input_only_pin_pullup_o)
        else $error("pull-up on while disabled");
    pullup_force_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        low_voltage_programming_enable_i |=> input_only_pin_pullup_o)
        else $error("pull-up not forced");
    slew_select_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == PEGPIO_SLEW_ADDR
        |=> port_e_slew_limited_o == $past(reg_wdata_i[4]))
        else $error("slew bit not stored");
    mux_pin0_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        capcomp3_pin_mux_i && !pwm3_output_a_en_i && LARGE_PKG
        |=> pin_out_o[0] == $past(lat_r[0]))
        else $error("pin 0 taken while muxed away");

    port_b_gate_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        gpu_dis_r |=> !port_b_pullup_gate_o)
        else $error("port B pull-ups allowed while disabled");
    unmapped_read_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i > PEGPIO_CFG_FOUR_LO_ADDR
        |=> reg_rdata_o == PEGPIO_ZERO_BYTE)
        else $error("unmapped read nonzero");
    sync_delay_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        ##2 1'b1 |-> sync2_r == $past(pin_in_i, 2))
        else $error("synchroniser latency wrong");

    pin0_pwm_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        pwm3_output_a_en_i && !capcomp3_pin_mux_i && LARGE_PKG
        |=> pin_out_o[0] == $past(pwm3_output_a_i))
        else $error("pin 0 not given to pwm");
    pin0_capture_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        capcomp_unit3_en_i && !pwm3_output_a_en_i && !capcomp3_pin_mux_i
        && LARGE_PKG |=> pin_out_o[0] == $past(capcomp_unit3_i))
        else $error("pin 0 not given to compare unit");
    pin1_pwm_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        pwm3_output_b_en_i && LARGE_PKG
        |=> pin_out_o[1] == $past(pwm3_output_b_i))
        else $error("pin 1 not given to pwm");
    pin2_compare_a: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        capcomp_unit5_en_i && LARGE_PKG
        |=> pin_out_o[2] == $past(capcomp_unit5_i))
        else $error("pin 2 not given to compare unit");
endmodule // pegpio_port_e
